/* File: rtl/ppi_pkg.sv */
// Constants for the programmable 24-line parallel port block
package ppi_pkg;

    // -------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------
    localparam logic [1:0] PPI_OFS_PORT_A = 2'h0;
    localparam logic [1:0] PPI_OFS_PORT_B = 2'h1;
    localparam logic [1:0] PPI_OFS_PORT_C = 2'h2;
    localparam logic [1:0] PPI_OFS_CONFIG = 2'h3;

    // -------------------------------------------------------------
    // Configuration word fields
    // -------------------------------------------------------------
    localparam logic [2:0] PPI_CW_FLAG = 3'h7;
    localparam logic [2:0] PPI_CW_A_MODE_HI = 3'h6;
    localparam logic [2:0] PPI_CW_A_MODE_LO = 3'h5;
    localparam logic [2:0] PPI_CW_A_IN = 3'h4;
    localparam logic [2:0] PPI_CW_CU_IN = 3'h3;
    localparam logic [2:0] PPI_CW_B_MODE = 3'h2;
    localparam logic [2:0] PPI_CW_B_IN = 3'h1;
    localparam logic [2:0] PPI_CW_CL_IN = 3'h0;
    localparam logic [2:0] PPI_SR_VALUE = 3'h0;

    // -------------------------------------------------------------
    // Port C handshake bit positions in strobed input
    // -------------------------------------------------------------
    localparam logic [2:0] PPI_C_A_FULL = 3'h5;
    localparam logic [2:0] PPI_C_A_ENABLE = 3'h4;
    localparam logic [2:0] PPI_C_A_REQUEST = 3'h3;
    localparam logic [2:0] PPI_C_B_ENABLE = 3'h2;
    localparam logic [2:0] PPI_C_B_FULL = 3'h1;
    localparam logic [2:0] PPI_C_B_REQUEST = 3'h0;
    localparam logic [7:0] PPI_C_A_HS_MASK = 8'h38;
    localparam logic [7:0] PPI_C_B_HS_MASK = 8'h07;

    // -------------------------------------------------------------
    // Values after reset
    // -------------------------------------------------------------
    localparam logic [7:0] PPI_CFG_RST = 8'h9b;
    localparam logic [7:0] PPI_PORT_RST = 8'h00;
    localparam logic [7:0] PPI_UNMAPPED_READ = 8'h00;

endpackage

/* File: rtl/ppi_port.sv */
// Programmable parallel port: basic and strobed input modes
`timescale 1ns/10ps
`default_nettype none

module ppi_port (
    // Clock, reset and clock enable
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    // Register port
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Port A pins
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe_n,
    // Port B pins
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe_n,
    // Port C pins
    input wire logic [7:0] pc_in,
    output logic [7:0] pc_out,
    output logic [7:0] pc_oe_n
);
    import ppi_pkg::*;

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------

    // Whole state of the block in one record
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] pa_lat;
        logic [7:0] pb_lat;
        logic [7:0] pc_lat;
        logic [7:0] a_in_lat;
        logic [7:0] b_in_lat;
        logic group_a_input_full;
        logic group_b_input_full;
        logic group_a_irq_enable;
        logic group_b_irq_enable;
        logic a_strobe_prev;
        logic b_strobe_prev;
        logic [7:0] rdata;
    } ppi_state_s;

    ppi_state_s st_q;
    ppi_state_s st_d;

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------

    // Live pins where the mask marks inputs, latch elsewhere
    function automatic logic [7:0] ppi_merge(
        input logic [7:0] lat,
        input logic [7:0] pins,
        input logic [7:0] in_mask
    );
        ppi_merge = (pins & in_mask) | (lat & ~in_mask);
    endfunction

    // -------------------------------------------------------------
    // Mode decode
    // -------------------------------------------------------------
    logic a_strobed;
    logic b_strobed;
    logic a_is_in;
    logic b_is_in;
    logic a_sin;
    logic b_sin;
    logic [7:0] hs_mask;
    logic [7:0] c_in_mask;
    logic [7:0] strobe_mask;
    logic group_a_strobe_n;
    logic group_b_strobe_n;
    logic group_a_irq_request;
    logic group_b_irq_request;
    logic a_strobe_fall;
    logic b_strobe_fall;
    logic [7:0] hs_val;

    // Group modes; all three group A mode codes above zero count as strobed
    assign a_strobed = st_q.cfg[PPI_CW_A_MODE_HI]
        | st_q.cfg[PPI_CW_A_MODE_LO];
    assign b_strobed = st_q.cfg[PPI_CW_B_MODE];
    assign a_is_in = st_q.cfg[PPI_CW_A_IN];
    assign b_is_in = st_q.cfg[PPI_CW_B_IN];
    assign a_sin = a_strobed & a_is_in;
    assign b_sin = b_strobed & b_is_in;

    // Port C bits owned by the handshake of each strobed group
    assign hs_mask = (a_strobed ? PPI_C_A_HS_MASK : 8'h00)
        | (b_strobed ? PPI_C_B_HS_MASK : 8'h00);

    // General port C inputs; handshake bits are never general
    assign c_in_mask = {{4{st_q.cfg[PPI_CW_CU_IN]}},
        {4{st_q.cfg[PPI_CW_CL_IN]}}} & ~hs_mask;

    // Strobe pins are inputs owned by their group
    assign strobe_mask = ({7'h00, a_strobed} << PPI_C_A_ENABLE)
        | ({7'h00, b_strobed} << PPI_C_B_ENABLE);
    assign group_a_strobe_n = pc_in[PPI_C_A_ENABLE];
    assign group_b_strobe_n = pc_in[PPI_C_B_ENABLE];

    // -------------------------------------------------------------
    // Handshake status
    // -------------------------------------------------------------

    // Requests follow enable and full with no extra state
    assign group_a_irq_request = st_q.group_a_irq_enable
        & st_q.group_a_input_full;
    assign group_b_irq_request = st_q.group_b_irq_enable
        & st_q.group_b_input_full;

    // Inputs are taken as synchronous, so one flop finds the edge
    assign a_strobe_fall = a_sin & st_q.a_strobe_prev
        & ~group_a_strobe_n;
    assign b_strobe_fall = b_sin & st_q.b_strobe_prev
        & ~group_b_strobe_n;

    // Status word; enable bits replace the strobe pin levels
    always_comb begin
        hs_val = 8'h00;
        hs_val[PPI_C_A_FULL] = st_q.group_a_input_full;
        hs_val[PPI_C_A_ENABLE] = st_q.group_a_irq_enable;
        hs_val[PPI_C_A_REQUEST] = group_a_irq_request;
        hs_val[PPI_C_B_ENABLE] = st_q.group_b_irq_enable;
        hs_val[PPI_C_B_FULL] = st_q.group_b_input_full;
        hs_val[PPI_C_B_REQUEST] = group_b_irq_request;
        hs_val = hs_val & hs_mask;
    end

    // -------------------------------------------------------------
    // Pin drive
    // -------------------------------------------------------------

    // Data ports drive their latch unless set as inputs
    assign pa_out = st_q.pa_lat;
    assign pb_out = st_q.pb_lat;
    assign pa_oe_n = {8{a_is_in}};
    assign pb_oe_n = {8{b_is_in}};

    // Port C drives latch on general bits, status on handshake bits
    assign pc_out = (st_q.pc_lat & ~hs_mask) | hs_val;
    assign pc_oe_n = c_in_mask | strobe_mask;

    // Read data stand from the flop one cycle after the strobe
    assign rdata = st_q.rdata;

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    logic [7:0] rd_val;
    logic [2:0] sr_sel;

    // Value that a read of the addressed register returns
    always_comb begin
        rd_val = PPI_UNMAPPED_READ;
        unique case (addr)
            PPI_OFS_PORT_A: begin
                if (a_sin) begin
                    rd_val = st_q.a_in_lat;
                end else begin
                    rd_val = ppi_merge(st_q.pa_lat, pa_in,
                        {8{a_is_in}});
                end
            end
            PPI_OFS_PORT_B: begin
                if (b_sin) begin
                    rd_val = st_q.b_in_lat;
                end else begin
                    rd_val = ppi_merge(st_q.pb_lat, pb_in,
                        {8{b_is_in}});
                end
            end
            PPI_OFS_PORT_C: begin
                rd_val = (ppi_merge(st_q.pc_lat, pc_in, c_in_mask)
                    & ~hs_mask) | hs_val;
            end
            PPI_OFS_CONFIG: begin
                // Write-only register reads as zero
                rd_val = PPI_UNMAPPED_READ;
            end
        endcase
    end

    assign sr_sel = wdata[3:1];

    // Register writes, read side effects and strobe captures
    always_comb begin
        st_d = st_q;
        st_d.a_strobe_prev = group_a_strobe_n;
        st_d.b_strobe_prev = group_b_strobe_n;

        // Reads: data out next cycle, strobed read empties the latch
        if (rd) begin
            st_d.rdata = rd_val;
            if (addr == PPI_OFS_PORT_A && a_sin) begin
                st_d.group_a_input_full = 1'b0;
            end
            if (addr == PPI_OFS_PORT_B && b_sin) begin
                st_d.group_b_input_full = 1'b0;
            end
        end

        // Writes
        if (wr) begin
            unique case (addr)
                PPI_OFS_PORT_A: begin
                    st_d.pa_lat = wdata;
                end
                PPI_OFS_PORT_B: begin
                    st_d.pb_lat = wdata;
                end
                PPI_OFS_PORT_C: begin
                    // Handshake bits are not writable as data
                    st_d.pc_lat = (st_q.pc_lat & hs_mask)
                        | (wdata & ~hs_mask);
                end
                PPI_OFS_CONFIG: begin
                    if (wdata[PPI_CW_FLAG]) begin
                        // New mode: outputs A and C restart at zero
                        st_d.cfg = wdata;
                        st_d.pa_lat = PPI_PORT_RST;
                        st_d.pc_lat = PPI_PORT_RST;
                        st_d.group_a_input_full = 1'b0;
                        st_d.group_b_input_full = 1'b0;
                        st_d.group_a_irq_enable = 1'b0;
                        st_d.group_b_irq_enable = 1'b0;
                    end else if (a_strobed
                        && sr_sel == PPI_C_A_ENABLE) begin
                        st_d.group_a_irq_enable =
                            wdata[PPI_SR_VALUE];
                    end else if (b_strobed
                        && sr_sel == PPI_C_B_ENABLE) begin
                        st_d.group_b_irq_enable =
                            wdata[PPI_SR_VALUE];
                    end else if (hs_mask[sr_sel] == 1'b0) begin
                        // Plain bit set/reset of a general line
                        st_d.pc_lat[sr_sel] = wdata[PPI_SR_VALUE];
                    end
                end
            endcase
        end

        // Captures come last so a strobe beats a same-cycle clear
        if (a_strobe_fall) begin
            st_d.a_in_lat = pa_in;
            st_d.group_a_input_full = 1'b1;
        end
        if (b_strobe_fall) begin
            st_d.b_in_lat = pb_in;
            st_d.group_b_input_full = 1'b1;
        end
    end

    // -------------------------------------------------------------
    // State register
    // -------------------------------------------------------------

    // Synchronous reset, which acts even with clock enable low; otherwise ce low freezes everything
    always_ff @(posedge mclk) begin
        if (reset) begin
            st_q.cfg <= PPI_CFG_RST;
            st_q.pa_lat <= PPI_PORT_RST;
            st_q.pb_lat <= PPI_PORT_RST;
            st_q.pc_lat <= PPI_PORT_RST;
            st_q.a_in_lat <= PPI_PORT_RST;
            st_q.b_in_lat <= PPI_PORT_RST;
            st_q.group_a_input_full <= 1'b0;
            st_q.group_b_input_full <= 1'b0;
            st_q.group_a_irq_enable <= 1'b0;
            st_q.group_b_irq_enable <= 1'b0;
            // Idle strobe is high; no false edge after reset
            st_q.a_strobe_prev <= 1'b1;
            st_q.b_strobe_prev <= 1'b1;
            st_q.rdata <= PPI_UNMAPPED_READ;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

endmodule // ppi_port

`default_nettype wire

/* File: sim/ppi_port_chk_assertions.sv */
// Checker of the parallel port block, bound to its ports
`timescale 1ns/10ps
`default_nettype none
module ppi_port_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    // Register port
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    // Port pins
    input wire logic [7:0] pa_out,
    input wire logic [7:0] pa_oe_n,
    input wire logic [7:0] pb_oe_n,
    input wire logic [7:0] pc_in,
    input wire logic [7:0] pc_out,
    input wire logic [7:0] pc_oe_n
);
    import ppi_pkg::*;
    logic [7:0] cfg_q;
    logic [1:0] en_q;
    logic cw, a_in, b_in;
    // Which groups are strobed inputs, from a shadow of the mode word
    assign cw = ce && wr && addr == 2'h3;
    assign a_in = cfg_q[7] && cfg_q[6:5] != 2'b00 && cfg_q[4];
    assign b_in = cfg_q[7] && cfg_q[2] && cfg_q[1];
    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_q <= PPI_CFG_RST;
        end else if (cw && wdata[7]) begin
            cfg_q <= wdata;
        end
    end
    // Enables move only by set/reset; mode writes drop them
    always_ff @(posedge mclk) begin
        if (reset || (cw && wdata[7])) begin
            en_q <= 2'b00;
        end else if (cw && a_in && wdata[3:1] == 3'h4) begin
            en_q[1] <= wdata[0];
        end else if (cw && b_in && wdata[3:1] == 3'h2) begin
            en_q[0] <= wdata[0];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    property p_mode_clr; cw && wdata[7] |=> pa_out == 8'h00
        && pc_out == 8'h00; endproperty
    a_mode_clr: assert property (p_mode_clr)
        else $error("outputs not cleared by mode word");
    property p_dir_a; cw && wdata[7] && wdata[6:5] == 2'b00 |=>
        pa_oe_n == {8{$past(wdata[4])}}
        && pc_oe_n[7:4] == {4{$past(wdata[3])}}; endproperty
    a_dir_a: assert property (p_dir_a)
        else $error("group A direction wrong");
    property p_dir_b; cw && wdata[7] && wdata[6:5] == 2'b00 && !wdata[2]
        |=> pb_oe_n == {8{$past(wdata[1])}}
        && pc_oe_n[3:0] == {4{$past(wdata[0])}}; endproperty
    a_dir_b: assert property (p_dir_b)
        else $error("group B direction wrong");
    property p_sr_bit; cw && !wdata[7] && (cfg_q & 8'h6d) == 8'h00
        |=> pc_out[$past(wdata[3:1])] == $past(wdata[0]); endproperty
    a_sr_bit: assert property (p_sr_bit)
        else $error("single bit set/reset missed");
    property p_req_a; a_in |-> pc_out[3] == (pc_out[5] && en_q[1]);
    endproperty
    a_req_a: assert property (p_req_a)
        else $error("group A request wrong");
    property p_req_b; b_in |-> pc_out[0] == (pc_out[1] && en_q[0]);
    endproperty
    a_req_b: assert property (p_req_b)
        else $error("group B request wrong");
    property p_full_a; a_in && ce && !pc_in[4] && $past(pc_in[4])
        |=> pc_out[5]; endproperty
    a_full_a: assert property (p_full_a)
        else $error("strobe did not set full");
    property p_rd_clr; a_in && ce && rd && addr == 2'h0 && pc_in[4]
        |=> !pc_out[5] && !pc_out[3]; endproperty
    a_rd_clr: assert property (p_rd_clr)
        else $error("data read did not clear full");
    property p_hs_a; a_in |-> pc_oe_n[5:3] == 3'b010; endproperty
    a_hs_a: assert property (p_hs_a)
        else $error("group A handshake pins wrong");
    // Main scenarios reached
    c_full_a: cover property (a_in && pc_out[5]);
    c_full_b: cover property (b_in && pc_out[1]);
    c_req_a: cover property (a_in && pc_out[3]);
endmodule // ppi_port_chk

bind ppi_port ppi_port_chk u_chk (.mclk(mclk), .reset(reset), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .pa_out(pa_out),
    .pa_oe_n(pa_oe_n), .pb_oe_n(pb_oe_n), .pc_in(pc_in),
    .pc_out(pc_out), .pc_oe_n(pc_oe_n));
`default_nettype wire

/* File: sim/ppi_periph.sv */
// Peripheral model driving the port pins and the input strobes
`timescale 1ns/10ps
`default_nettype none
module ppi_periph (
    // Clock
    input wire logic mclk,
    // Drive from the block
    input wire logic [7:0] pa_out,
    input wire logic [7:0] pa_oe_n,
    input wire logic [7:0] pb_out,
    input wire logic [7:0] pb_oe_n,
    input wire logic [7:0] pc_out,
    input wire logic [7:0] pc_oe_n,
    // Levels seen by the block
    output logic [7:0] pa_in,
    output logic [7:0] pb_in,
    output logic [7:0] pc_in
);
    logic [7:0] ext_a = 8'h00;
    logic [7:0] ext_b = 8'h00;
    logic [7:0] ext_c = 8'h00;
    logic [1:0] stb = 2'b11;
    logic [7:0] ext_cs;
    // Strobes sit on C bits 4 and 2, idle high between transfers
    assign ext_cs = {ext_c[7:5], stb[1], ext_c[3], stb[0], ext_c[1:0]};
    // A line shows the block where it drives, else our own value
    assign pa_in = (pa_out & ~pa_oe_n) | (ext_a & pa_oe_n);
    assign pb_in = (pb_out & ~pb_oe_n) | (ext_b & pb_oe_n);
    assign pc_in = (pc_out & ~pc_oe_n) | (ext_cs & pc_oe_n);
    // One strobe pulse; data is dropped right after the capture edge
    task automatic strobe(input logic grp, input logic [7:0] d);
        @(posedge mclk);
        if (grp) ext_a <= d;
        else ext_b <= d;
        stb[grp] <= 1'b0;
        @(posedge mclk);
        stb[grp] <= 1'b1;
        if (grp) ext_a <= ~d;
        else ext_b <= ~d;
    endtask
endmodule // ppi_periph
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the parallel port block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    n_fail++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
    import ppi_pkg::*;
    logic mclk, reset, ce, wr, rd;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, w, pa_in, pb_in, pc_in;
    logic [7:0] pa_out, pa_oe_n, pb_out, pb_oe_n, pc_out, pc_oe_n;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    ppi_port dut (.mclk(mclk), .reset(reset), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pa_in(pa_in),
        .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_in(pb_in),
        .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pc_in(pc_in),
        .pc_out(pc_out), .pc_oe_n(pc_oe_n));
    ppi_periph p (.mclk(mclk), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
        .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pc_out(pc_out),
        .pc_oe_n(pc_oe_n), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in));
    // Clock, and a ceiling on run length
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            wrap_up();
        end
    end
    // -----------------------------------------------------------
    // Bus tasks: one strobe cycle, then one idle cycle
    // -----------------------------------------------------------
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
        #1;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        // Read data stand from the cycle after the strobe until the next read
        @(posedge mclk);
        v = rdata;
        #1;
    endtask
    task automatic chk_rd(input logic [1:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd_reg(a, v);
        `CHK("rdata", e, v)
    endtask
    // Poll port C as software would, bounded
    task automatic poll(input logic [7:0] m);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 4 && (v & m) == 8'h00; i++) rd_reg(2'h2, v);
        `CHK("poll", m, v & m)
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        wr = 1'b0;
        ce = 1'b1;
        rd = 1'b0;
        addr = 2'h0;
        wdata = 8'h00;
        reset = 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        `CHK("pa_oe_n", 8'hff, pa_oe_n)
        chk_rd(PPI_OFS_CONFIG, 8'h00);
        // Every basic direction word, outputs A and C dirty beforehand
        for (int i = 0; i < 16; i++) begin
            w = {3'b100, i[3], i[2], 1'b0, i[1], i[0]};
            wr_reg(PPI_OFS_PORT_A, 8'hff);
            wr_reg(PPI_OFS_PORT_C, 8'hff);
            wr_reg(PPI_OFS_CONFIG, w);
            `CHK("pa_oe_n", {8{w[4]}}, pa_oe_n)
            `CHK("pc_oe_n", {{4{w[3]}}, {4{w[0]}}}, pc_oe_n)
            `CHK("pb_oe_n", {8{w[1]}}, pb_oe_n)
            `CHK("a c out", 16'h0000, {pa_out, pc_out})
        end
        wr_reg(PPI_OFS_CONFIG, 8'h80);
        wr_reg(PPI_OFS_PORT_A, 8'h12);
        wr_reg(PPI_OFS_PORT_B, 8'h34);
        wr_reg(PPI_OFS_PORT_C, 8'h56);
        `CHK("outs", 24'h123456, {pa_out, pb_out, pc_out})
        // Clock enable low: the write is not taken, the latch holds
        ce <= 1'b0;
        wr_reg(PPI_OFS_PORT_A, 8'hee);
        ce <= 1'b1;
        `CHK("pa_out", 8'h12, pa_out)
        wr_reg(PPI_OFS_CONFIG, 8'h90);
        `CHK("pc_out", 8'h00, pc_out)
        p.ext_a = 8'h3c;
        chk_rd(PPI_OFS_PORT_A, 8'h3c);
        p.ext_a = 8'hc3;
        chk_rd(PPI_OFS_PORT_A, 8'hc3);
        wr_reg(PPI_OFS_CONFIG, 8'h0b);
        `CHK("pc_out", 8'h20, pc_out)
        wr_reg(PPI_OFS_CONFIG, 8'h0a);
        `CHK("pc_out", 8'h00, pc_out)
        wr_reg(PPI_OFS_CONFIG, 8'h89);
        p.ext_c = 8'hb5;
        chk_rd(PPI_OFS_PORT_C, 8'hb5);
        // Strobed input on A, with and without the enable
        wr_reg(PPI_OFS_CONFIG, 8'hb0);
        wr_reg(PPI_OFS_CONFIG, 8'h09);
        p.strobe(1'b1, 8'h5a);
        poll(8'h20);
        chk_rd(PPI_OFS_PORT_C, 8'h38);
        chk_rd(PPI_OFS_PORT_A, 8'h5a);
        chk_rd(PPI_OFS_PORT_C, 8'h10);
        wr_reg(PPI_OFS_CONFIG, 8'h0f);
        `CHK("pc_out7", 1'b1, pc_out[7])
        wr_reg(PPI_OFS_CONFIG, 8'h08);
        p.strobe(1'b1, 8'h66);
        poll(8'h20);
        chk_rd(PPI_OFS_PORT_C, 8'ha0);
        chk_rd(PPI_OFS_PORT_A, 8'h66);
        // Upper mode code of group A is strobed too; only strobe is input
        wr_reg(PPI_OFS_CONFIG, 8'hd0);
        `CHK("pc_oe_n", 8'h10, pc_oe_n)
        // Strobed input on B; set/reset of its full bit is ignored
        wr_reg(PPI_OFS_CONFIG, 8'h86);
        wr_reg(PPI_OFS_CONFIG, 8'h05);
        `CHK("pc_oe_n", 8'h04, pc_oe_n)
        p.strobe(1'b0, 8'ha5);
        poll(8'h02);
        chk_rd(PPI_OFS_PORT_C, 8'h07);
        chk_rd(PPI_OFS_PORT_B, 8'ha5);
        wr_reg(PPI_OFS_CONFIG, 8'h03);
        chk_rd(PPI_OFS_PORT_C, 8'h04);
        // Reset in mid-run acts even with the clock enable low
        ce <= 1'b0;
        reset <= 1'b1;
        @(posedge mclk);
        reset <= 1'b0;
        ce <= 1'b1;
        @(posedge mclk);
        #1;
        `CHK("reset oe", 24'hffffff, {pa_oe_n, pb_oe_n, pc_oe_n})
        `CHK("pb_out", PPI_PORT_RST, pb_out)
        chk_rd(PPI_OFS_PORT_B, 8'h5a);
        wrap_up();
    end
endmodule // tb
`default_nettype wire
